//--- rtl/bcc_pkg.sv
// constants shared by the buffered capture/compare timer
// assumes a 32-bit AHB-Lite register port and one 125 MHz core clock
`default_nettype none
package bcc_pkg;
   localparam int NUM_CH = 5;                       // timer channels
   localparam int DMA_CH = 4;                       // channels whose A request may start a transfer
   localparam int NUM_BR = 3;                       // buffer registers: ch3 A, ch3 B, ch4 B
   localparam int CLK_PERIOD_NS = 8;                // core clock period
   // per-channel register offsets, channel stride in bytes
   localparam logic [7:0] CH_SPAN  = 8'h20;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_CNT  = 8'h08;
   localparam logic [7:0] OFF_GRA  = 8'h0C;
   localparam logic [7:0] OFF_GRB  = 8'h10;
   localparam logic [7:0] OFF_BRA  = 8'h14;
   localparam logic [7:0] OFF_BRB  = 8'h18;
   // shared register offsets
   localparam logic [7:0] OFF_RUN  = 8'hA0;
   localparam logic [7:0] OFF_FUNC = 8'hA4;
   localparam logic [7:0] OFF_OUTC = 8'hA8;
   // channel control fields
   localparam int CTL_W        = 13;
   localparam int CTL_PSC_LSB  = 0;
   localparam int CTL_CLR_LSB  = 2;
   localparam int CTL_CAPA     = 4;
   localparam int CTL_EDGA_LSB = 6;
   localparam int CTL_IEA      = 10;
   localparam int CTL_IEW      = 12;
   localparam logic [1:0] CLR_A = 2'h1;
   localparam logic [1:0] CLR_B = 2'h2;
   // status flag positions
   localparam int FLG_A = 0;
   localparam int FLG_B = 1;
   localparam int FLG_W = 2;
   // function control fields
   localparam int FN_BUF_A3 = 2;
   localparam int FN_BUF_B3 = 3;
   localparam int FN_BUF_B4 = 4;
   localparam logic [1:0] MODE_COMP  = 2'h2;
   localparam logic [1:0] MODE_RSYNC = 2'h3;
   // reset values
   localparam logic [15:0]      CNT_RST  = 16'h0000;
   localparam logic [15:0]      GR_RST   = 16'hFFFF;
   localparam logic [CTL_W-1:0] CTRL_RST = 13'h0000;
   localparam logic [4:0]       FUNC_RST = 5'h00;
   // three-state cpu access cycle
   typedef enum logic [1:0] {BS_IDLE, BS_T2, BS_T3} bcc_bus_e;
endpackage
`default_nettype wire

//--- rtl/bcc_timer.sv
// five-channel 16-bit capture/compare timer with buffer registers and an AHB-Lite slave
// assumes pins arrive asynchronously; requests go to an outside interrupt and transfer controller
//
// Overview of operation
// [R01] buffer registers exist on channels 3, 4 only
// [R02] compare match copies buffer into general register
// [R03] capture: counter into general, old into buffer
// [R04] complementary mode: copy at A3 up-match, ch4 underflow
// [R05] reset-synchronized mode: copy at A3 match
// [R06] only enabled registers use buffers
// [R07] polarity bits invert ch3/ch4 pins in PWM
// [R08] match flag set as counter leaves match
// [R09] capture sets flag and loads counter value
// [R10] wrap flag on FFFF-0000 or 0000-FFFF
// [R11] flag clears by read-one then write-zero
// [R12] fifteen requests: flag and enable both set
// [R13] only channel 0-3 A requests start transfers
// [R14] request order channel 0 to 4, A,B,wrap
// [R15] clear in write T3 wins, data dropped
// [R16] word write T3 suppresses increment
// [R17] byte write T2/T3: no increment either half
// [R18] ch3 B above A3: output never toggles (code toggles on every ch3 B match, e.g. B3 = A3+1 in complementary mode)
// [R19] general write T3 suppresses compare match
// [R20] capture in T3 wins over general write
// [R21] capture in T3 wins over buffer write
// [R22] complementary: A3 flag up-match, ch4 wrap underflow
// [R23] each cpu access is a three-state cycle
// [R24] per-flag record of being read as one
`timescale 1ns/100ps
`default_nettype none
module bcc_timer
   import bcc_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic [31:0]            hrdata,
   output logic                   hresp,
   input  wire logic [NUM_CH-1:0] timer_pin_a_in,
   input  wire logic [NUM_CH-1:0] timer_pin_b_in,
   output logic [NUM_CH-1:0]      timer_pin_a_out,
   output logic [NUM_CH-1:0]      timer_pin_a_oe,
   output logic [NUM_CH-1:0]      timer_pin_b_out,
   output logic [NUM_CH-1:0]      timer_pin_b_oe,
   output logic [NUM_CH-1:0]      match_capture_irq_a,
   output logic [NUM_CH-1:0]      match_capture_irq_b,
   output logic [NUM_CH-1:0]      wrap_irq,
   output logic [DMA_CH-1:0]      dma_req
);

   ////////////////////////////////////////////////////////////////////////////////
   // helper functions

   // register hit for a channel slot
   function automatic logic hit(input logic [7:0] a, input int c, input logic [7:0] off);
      return (a[7:5] == 3'(c)) && (a[4:0] == off[4:0]);
   endfunction

   // byte-lane merge of write data into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] w, input logic [3:0] be);
      return {be[1] ? w[15:8] : o[15:8], be[0] ? w[7:0] : o[7:0]};
   endfunction

   // byte enables from size and low address
   function automatic logic [3:0] byte_en(input logic [2:0] sz, input logic [1:0] a);
      case (sz)
         3'h0: byte_en = 4'h1 << a;
         3'h1: byte_en = a[1] ? 4'hC : 4'h3;
         default: byte_en = 4'hF;
      endcase
   endfunction

   // prescaler tap mask
   function automatic logic [2:0] psc_mask(input logic [1:0] sel);
      case (sel)
         2'h0: psc_mask = 3'h0;
         2'h1: psc_mask = 3'h1;
         2'h2: psc_mask = 3'h3;
         default: psc_mask = 3'h7;
      endcase
   endfunction

   // buffer enable per channel and register, none below channel 3
   function automatic logic buf_on(input logic [4:0] fn, input int c, input int ab);
      if (c == 3)
         return (ab == 0) ? fn[FN_BUF_A3] : fn[FN_BUF_B3]; // R01
      else if (c == 4 && ab == 1)
         return fn[FN_BUF_B4];
      else
         return 1'b0;
   endfunction

   // buffer slot of a channel register
   function automatic int br_idx(input int c, input int ab);
      return (c == 3) ? ab : 2;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // state

   bcc_bus_e           st_r, st_nxt;
   logic [7:0]         addr_r;
   logic               wr_r;
   logic [3:0]         be_r;
   logic               accept, wr_t3;
   logic [31:0]        rd_nxt;
   logic [CTL_W-1:0]   ctrl_r [NUM_CH];
   logic [NUM_CH-1:0]  run_r;
   logic [4:0]         func_r;
   logic [1:0]         outc_r;
   logic [2:0]         psc_r;
   logic               dir_down_r;
   logic [15:0]        cnt_r [NUM_CH];
   logic [15:0]        gr_r [NUM_CH][2];
   logic [15:0]        br_r [NUM_BR];
   logic [2:0]         flag_r [NUM_CH];
   logic [2:0]         seen_r [NUM_CH];
   logic [NUM_CH-1:0]  s1_r [2];
   logic [NUM_CH-1:0]  s2_r [2];
   logic [NUM_CH-1:0]  s3_r [2];
   logic [NUM_CH-1:0]  lvl_r [2];
   logic [NUM_CH-1:0]  tick, up, wrap_up, wrap_dn, clr, cnt_wr, byte_win;
   logic [1:0]         cmp [NUM_CH];
   logic [1:0]         cap [NUM_CH];
   logic [2:0]         fset [NUM_CH];
   logic               comp_md, rsync_md, a3_up, c4_unf;

   assign comp_md  = (func_r[1:0] == MODE_COMP);
   assign rsync_md = (func_r[1:0] == MODE_RSYNC);
   assign accept   = hsel && hready && htrans[1];
   assign wr_t3    = (st_r == BS_T3) && wr_r;

   ////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: address phase, T2 wait state, T3 completion

   // next bus state
   always_comb begin
      case (st_r)
         BS_IDLE: st_nxt = accept ? BS_T2 : BS_IDLE; // R23
         BS_T2:   st_nxt = BS_T3;
         BS_T3:   st_nxt = accept ? BS_T2 : BS_IDLE;
         default: st_nxt = BS_IDLE;
      endcase
   end

   // bus state and captured address phase
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_r      <= BS_IDLE;
         addr_r    <= 8'h00;
         wr_r      <= 1'b0;
         be_r      <= 4'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         hreadyout <= (st_nxt != BS_T2);
         hresp     <= 1'b0;                       // always OKAY
         if (accept && st_r != BS_T2) begin
            addr_r <= haddr[7:0];
            wr_r   <= hwrite;
            be_r   <= byte_en(hsize, haddr[1:0]);
         end
      end
   end

   // read mux, sampled in T2 so a T3 capture is not seen
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (addr_r == OFF_RUN)
         rd_nxt = {27'h0, run_r};
      else if (addr_r == OFF_FUNC)
         rd_nxt = {27'h0, func_r};
      else if (addr_r == OFF_OUTC)
         rd_nxt = {30'h0, outc_r};
      for (int c = 0; c < NUM_CH; c++) begin
         if (hit(addr_r, c, OFF_CTRL)) rd_nxt = {19'h0, ctrl_r[c]};
         if (hit(addr_r, c, OFF_STAT)) rd_nxt = {29'h0, flag_r[c]};
         if (hit(addr_r, c, OFF_CNT))  rd_nxt = {16'h0, cnt_r[c]};
         if (hit(addr_r, c, OFF_GRA))  rd_nxt = {16'h0, gr_r[c][0]};
         if (hit(addr_r, c, OFF_GRB))  rd_nxt = {16'h0, gr_r[c][1]};
         if (c == 3 && hit(addr_r, c, OFF_BRA)) rd_nxt = {16'h0, br_r[0]};
         if (c >= 3 && hit(addr_r, c, OFF_BRB)) rd_nxt = {16'h0, br_r[br_idx(c, 1)]};
      end
   end

   // read data register
   always_ff @(posedge core_clk) begin
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (st_r == BS_T2 && !wr_r)
         hrdata <= rd_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control registers

   // run, function, output level and channel control writes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         run_r  <= 5'h00;
         func_r <= FUNC_RST;
         outc_r <= 2'h0;
         for (int c = 0; c < NUM_CH; c++) ctrl_r[c] <= CTRL_RST;
      end else if (wr_t3) begin
         if (addr_r == OFF_RUN && be_r[0])  run_r  <= hwdata[4:0];
         if (addr_r == OFF_FUNC && be_r[0]) func_r <= hwdata[4:0]; // R06
         if (addr_r == OFF_OUTC && be_r[0]) outc_r <= hwdata[1:0];
         for (int c = 0; c < NUM_CH; c++)
            if (hit(addr_r, c, OFF_CTRL))
               ctrl_r[c] <= {be_r[1] ? hwdata[12:8] : ctrl_r[c][12:8], be_r[0] ? hwdata[7:0] : ctrl_r[c][7:0]};
      end
   end

   // free-running prescaler
   always_ff @(posedge core_clk) begin
      if (rst)
         psc_r <= 3'h0;
      else
         psc_r <= psc_r + 3'h1;
   end

   // pin synchronisers, third stage for edge detection
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int ab = 0; ab < 2; ab++) begin
            s1_r[ab] <= 5'h00;
            s2_r[ab] <= 5'h00;
            s3_r[ab] <= 5'h00;
         end
      end else begin
         s1_r[0] <= timer_pin_a_in;
         s1_r[1] <= timer_pin_b_in;
         for (int ab = 0; ab < 2; ab++) begin
            s2_r[ab] <= s1_r[ab];
            s3_r[ab] <= s2_r[ab];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // timer events

   // ticks, matches, captures, wraps and clears per channel
   always_comb begin
      logic       capm;
      logic [1:0] edg;
      logic       rise;
      logic       fall;
      capm = 1'b0;
      edg  = 2'h0;
      rise = 1'b0;
      fall = 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
         up[c]   = !(comp_md && c >= 3 && dir_down_r);
         tick[c] = run_r[c] && ((psc_r & psc_mask(ctrl_r[c][CTL_PSC_LSB +: 2])) == 3'h0);
         for (int ab = 0; ab < 2; ab++) begin
            capm = ctrl_r[c][CTL_CAPA + ab];
            edg  = ctrl_r[c][CTL_EDGA_LSB + 2 * ab +: 2];
            rise = s2_r[ab][c] && !s3_r[ab][c];
            fall = !s2_r[ab][c] && s3_r[ab][c];
            cap[c][ab] = capm && ((edg[0] && rise) || (edg[1] && fall));
            // match on the tick that leaves the matching count
            cmp[c][ab] = !capm && tick[c] && (cnt_r[c] == gr_r[c][ab]) // R08
                         && !(wr_t3 && hit(addr_r, c, (ab == 0) ? OFF_GRA : OFF_GRB)); // R19
         end
         wrap_up[c]  = tick[c] && up[c] && (cnt_r[c] == 16'hFFFF);
         wrap_dn[c]  = tick[c] && !up[c] && (cnt_r[c] == 16'h0000);
         clr[c]      = ((ctrl_r[c][CTL_CLR_LSB +: 2] == CLR_A) && (cmp[c][0] || cap[c][0]))
                    || ((ctrl_r[c][CTL_CLR_LSB +: 2] == CLR_B) && (cmp[c][1] || cap[c][1]))
                    || (rsync_md && c == 3 && cmp[c][0]);
         cnt_wr[c]   = wr_t3 && hit(addr_r, c, OFF_CNT);
         byte_win[c] = wr_r && (st_r != BS_IDLE) && hit(addr_r, c, OFF_CNT) && (be_r[1:0] != 2'h3);
      end
      a3_up  = comp_md && cmp[3][0] && !dir_down_r;
      c4_unf = comp_md && wrap_dn[4];
      for (int c = 0; c < NUM_CH; c++) begin
         fset[c][FLG_A] = (comp_md && c == 3) ? a3_up : (cmp[c][0] || cap[c][0]); // R22
         fset[c][FLG_B] = cmp[c][1] || cap[c][1];                                   // R09
         fset[c][FLG_W] = (comp_md && c == 4) ? wrap_dn[c] : (wrap_up[c] || wrap_dn[c]); // R10
      end
   end

   // up/down direction shared by channels 3 and 4
   always_ff @(posedge core_clk) begin
      if (rst || !comp_md)
         dir_down_r <= 1'b0;
      else if (a3_up)
         dir_down_r <= 1'b1;
      else if (c4_unf)
         dir_down_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // counters, general and buffer registers

   // counter: clear beats write beats increment
   always_ff @(posedge core_clk) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (rst)
            cnt_r[c] <= CNT_RST;
         else if (clr[c])
            cnt_r[c] <= CNT_RST;                     // R15
         else if (cnt_wr[c])
            cnt_r[c] <= merge16(cnt_r[c], hwdata, be_r); // R16
         else if (tick[c] && !byte_win[c])          // R17
            cnt_r[c] <= up[c] ? cnt_r[c] + 16'h1 : cnt_r[c] - 16'h1;
      end
   end

   // general registers: capture, then buffer copy, then cpu write
   always_ff @(posedge core_clk) begin
      for (int c = 0; c < NUM_CH; c++) begin
         for (int ab = 0; ab < 2; ab++) begin
            if (rst)
               gr_r[c][ab] <= GR_RST;
            else if (cap[c][ab])
               gr_r[c][ab] <= cnt_r[c];             // R09 R20
            else if (buf_on(func_r, c, ab) && (comp_md ? (a3_up || c4_unf)   // R04
                                             : rsync_md ? cmp[3][0]         // R05
                                             : cmp[c][ab]))                 // R02
               gr_r[c][ab] <= br_r[br_idx(c, ab)];
            else if (wr_t3 && hit(addr_r, c, (ab == 0) ? OFF_GRA : OFF_GRB))
               gr_r[c][ab] <= merge16(gr_r[c][ab], hwdata, be_r);
         end
      end
   end

   // buffer registers: slot 0 ch3 A, 1 ch3 B, 2 ch4 B
   always_ff @(posedge core_clk) begin
      for (int k = 0; k < NUM_BR; k++) begin
         if (rst)
            br_r[k] <= GR_RST;
         else if (buf_on(func_r, (k < 2) ? 3 : 4, (k == 0) ? 0 : 1) && cap[(k < 2) ? 3 : 4][(k == 0) ? 0 : 1])
            br_r[k] <= gr_r[(k < 2) ? 3 : 4][(k == 0) ? 0 : 1]; // R03 R21
         else if (wr_t3 && hit(addr_r, (k < 2) ? 3 : 4, (k == 0) ? OFF_BRA : OFF_BRB))
            br_r[k] <= merge16(br_r[k], hwdata, be_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status flags with read-as-one record

   // set wins over clear; clear needs an earlier read as one
   always_ff @(posedge core_clk) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (rst) begin
            flag_r[c] <= 3'h0;
            seen_r[c] <= 3'h0;                       // R24
         end else if (wr_t3 && hit(addr_r, c, OFF_STAT) && be_r[0]) begin
            flag_r[c] <= fset[c] | (flag_r[c] & ~(seen_r[c] & ~hwdata[2:0])); // R11
            seen_r[c] <= seen_r[c] & hwdata[2:0];
         end else begin
            flag_r[c] <= fset[c] | flag_r[c];
            if (st_r == BS_T2 && !wr_r && hit(addr_r, c, OFF_STAT))
               seen_r[c] <= seen_r[c] | flag_r[c];  // R24
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pins and requests

   // pin levels toggle on compare match, inverted for ch3/ch4 in PWM modes
   always_ff @(posedge core_clk) begin
      for (int ab = 0; ab < 2; ab++) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (rst) begin
               lvl_r[ab][c] <= 1'b0;
            end else if (cmp[c][ab]) begin
               lvl_r[ab][c] <= !lvl_r[ab][c];       // R18
            end
         end
      end
   end

   // pin output flops
   always_ff @(posedge core_clk) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (rst) begin
            timer_pin_a_out[c] <= 1'b0;
            timer_pin_b_out[c] <= 1'b0;
            timer_pin_a_oe[c]  <= 1'b0;
            timer_pin_b_oe[c]  <= 1'b0;
         end else begin
            // index kept in range for channels below 3, where polarity never applies
            timer_pin_a_out[c] <= lvl_r[0][c] ^ ((comp_md || rsync_md) && c >= 3 && outc_r[(c >= 3) ? c - 3 : 0]); // R07
            timer_pin_b_out[c] <= lvl_r[1][c] ^ ((comp_md || rsync_md) && c >= 3 && outc_r[(c >= 3) ? c - 3 : 0]);
            timer_pin_a_oe[c]  <= !ctrl_r[c][CTL_CAPA];
            timer_pin_b_oe[c]  <= !ctrl_r[c][CTL_CAPA + 1];
         end
      end
   end

   // request lines, bit 0 highest ranked
   always_ff @(posedge core_clk) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (rst) begin
            match_capture_irq_a[c] <= 1'b0;
            match_capture_irq_b[c] <= 1'b0;
            wrap_irq[c]            <= 1'b0;
         end else begin
            match_capture_irq_a[c] <= flag_r[c][FLG_A] && ctrl_r[c][CTL_IEA];     // R12 R14
            match_capture_irq_b[c] <= flag_r[c][FLG_B] && ctrl_r[c][CTL_IEA + 1];
            wrap_irq[c]            <= flag_r[c][FLG_W] && ctrl_r[c][CTL_IEW];
         end
      end
      for (int c = 0; c < DMA_CH; c++) begin
         if (rst)
            dma_req[c] <= 1'b0;
         else
            dma_req[c] <= flag_r[c][FLG_A] && ctrl_r[c][CTL_IEA]; // R13
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_cap3a_buf;
      cap[3][0] && buf_on(func_r, 3, 0);
   endsequence

   a_match_late_flag: // R08
      assert property (cmp[0][0] |=> flag_r[0][FLG_A]) else $error("match did not set flag A");
   a_cap_loads_gr: // R09
      assert property (cap[1][1] |=> gr_r[1][1] == $past(cnt_r[1]) && flag_r[1][FLG_B])
         else $error("capture did not load general register");
   a_cap_buffer_shift: // R03
      assert property (s_cap3a_buf |=> br_r[0] == $past(gr_r[3][0]) && gr_r[3][0] == $past(cnt_r[3]))
         else $error("capture buffer shift wrong");
   a_wrap_sets_flag: // R10
      assert property (wrap_up[4] && !clr[4] && !cnt_wr[4] |=> cnt_r[4] == 16'h0000 && flag_r[4][FLG_W])
         else $error("wrap flag not set");
   a_flag_clear_gate: // R11
      assert property ($fell(flag_r[0][FLG_A]) |-> $past(seen_r[0][FLG_A]) && $past(wr_t3))
         else $error("flag cleared without read");
   a_clear_beats_write: // R15
      assert property (clr[1] && cnt_wr[1] |=> cnt_r[1] == 16'h0000) else $error("write beat clear");
   a_word_write_wins: // R16
      assert property (cnt_wr[4] && !clr[4] && be_r == 4'hF |=> cnt_r[4] == $past(hwdata[15:0]))
         else $error("increment not suppressed");
   a_irq_follows_flag: // R12
      assert property ((flag_r[4][FLG_W] && ctrl_r[4][CTL_IEW])[*2] |-> wrap_irq[4])
         else $error("request missing");
   a_dma_needs_flag: // R13
      assert property (dma_req[3] |-> $past(flag_r[3][FLG_A])) else $error("spurious transfer request");
   a_bus_t3_ready: // R23
      assert property ($rose(st_r == BS_T2) |-> !hreadyout ##1 hreadyout) else $error("wait state wrong");

endmodule
`default_nettype wire

//--- verif/bcc_irq_sink.sv
// request sink model: ranks the fifteen timer requests
// assumes level requests that stay up while flag and enable are set
`timescale 1ns/100ps
`default_nettype none
module bcc_irq_sink
   import bcc_pkg::*;
(
   input  wire logic [NUM_CH-1:0] req_a,
   input  wire logic [NUM_CH-1:0] req_b,
   input  wire logic [NUM_CH-1:0] req_w,
   output logic [4:0]             top_src
);
   // lowest channel wins, then A, B, wrap; 1F means none
   always_comb begin
      top_src = 5'h1F;
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         if (req_w[c]) top_src = 5'(3 * c + 2);
         if (req_b[c]) top_src = 5'(3 * c + 1);
         if (req_a[c]) top_src = 5'(3 * c);
      end
   end
endmodule
`default_nettype wire

//--- verif/bcc_timer_bench.sv
// self-checking bench for the capture/compare timer
// assumes the sink model and one 125 MHz clock
`timescale 1ns/100ps
`default_nettype none
module bcc_timer_bench
   import bcc_pkg::*;
   ;
   logic              core_clk, rst, hsel, hwrite;
   logic [31:0]       haddr, hwdata, rd;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [NUM_CH-1:0] pin_a, pin_b;
   wire logic         hreadyout;
   wire logic         hr;
   wire logic [31:0]  hrdata;
   wire logic [NUM_CH-1:0] ia, ib, iw, pa, pao, pb, pbo;
   wire logic [DMA_CH-1:0] dma;
   wire logic [4:0]   top;
   int                errors, checks, cyc, seed, g;
   logic [31:0]       mdl_q[$];
   bcc_timer i_bcc_timer (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hr), .timer_pin_a_in(pin_a), .timer_pin_b_in(pin_b), .timer_pin_a_out(pa),
      .timer_pin_a_oe(pao), .timer_pin_b_out(pb), .timer_pin_b_oe(pbo), .match_capture_irq_a(ia),
      .match_capture_irq_b(ib), .wrap_irq(iw), .dma_req(dma));
   bcc_irq_sink i_bcc_irq_sink (.req_a(ia), .req_b(ib), .req_w(iw), .top_src(top));
   ////////////////////////////////////////////////////////////////
   // clock source
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // one single-word transfer, read data left in rd
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", 0, {31'h0, hr});
   endtask
   // compare and count
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {rst, hsel, hwrite, haddr, hwdata, htrans, pin_a, pin_b} = '0;
      hsize = 3'h2;
      rst = 1'b1;
      seed = 32'h4be3bdcf;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      bus(0, OFF_CNT, 0);
      chk("cnt0", {16'h0, CNT_RST}, rd);
      bus(0, OFF_GRA, 0);
      chk("gra0", {16'h0, GR_RST}, rd);
      bus(0, 8'hAC, 0);
      chk("unmapped", 0, rd);
      bus(1, OFF_BRA, 32'h1234);
      bus(0, OFF_BRA, 0);
      chk("ch0 bra", 0, rd);
      $display("test reset done");
      // periodic compare on ch0, flag clear protocol
      g = 8 + ($random(seed) & 31);
      bus(1, OFF_GRA, 32'(g));
      bus(1, OFF_CTRL, 32'h404);
      bus(1, OFF_RUN, 1);
      while (ia[0] !== 1'b1) @(posedge core_clk);
      chk("dma0", 1, 32'(dma[0]));
      chk("top", 0, 32'(top));
      bus(1, OFF_RUN, 0);
      bus(1, OFF_STAT, 0);
      bus(0, OFF_STAT, 0);
      chk("flag kept", 1, 32'(rd[FLG_A]));
      bus(1, OFF_STAT, 0);
      bus(0, OFF_STAT, 0);
      chk("flag clr", 0, 32'(rd[FLG_A]));
      chk("irq a0", 0, 32'(ia[0]));
      chk("pin a0", 1, 32'(pa[0]));
      chk("oe a0", 1, 32'(pao[0]));
      $display("test compare done");
      // ch3 buffered compare
      mdl_q.push_back(32'(g + 50));
      bus(1, OFF_FUNC, 32'(1 << FN_BUF_A3));
      bus(1, 8'h60 + OFF_GRA, 32'(g));
      bus(1, 8'h60 + OFF_BRA, mdl_q[0]);
      bus(1, 8'h60 + OFF_CTRL, 32'h404);
      bus(1, OFF_RUN, 8);
      while (ia[3] !== 1'b1) @(posedge core_clk);
      chk("dma3", 1, 32'(dma[3]));
      bus(1, OFF_RUN, 0);
      bus(0, 8'h60 + OFF_GRA, 0);
      chk("ch3 gra", mdl_q.pop_front(), rd);
      // buffered capture on ch3 A: old general value moves into the buffer
      mdl_q.push_back(32'(g + 50));
      bus(1, 8'h60 + OFF_BRA, 0);
      bus(1, 8'h60 + OFF_CTRL, 32'h50);
      pin_a[3] <= 1'b1;
      repeat (8) @(posedge core_clk);
      bus(0, 8'h60 + OFF_BRA, 0);
      chk("ch3 bra", mdl_q.pop_front(), rd);
      $display("test buffer done");
      // ch1 capture B on rising pin
      bus(1, 8'h20 + OFF_CTRL, 32'h920);
      bus(1, OFF_RUN, 2);
      pin_b[1] <= 1'b1;
      while (ib[1] !== 1'b1) @(posedge core_clk);
      chk("dma1", 0, 32'(dma[1]));
      bus(1, OFF_RUN, 0);
      bus(0, 8'h20 + OFF_STAT, 0);
      chk("cap flag", 1, 32'(rd[FLG_B]));
      chk("oe b1", 0, 32'(pbo[1]));
      // ch1 cleared every tick; a counter write in T3 must be dropped
      bus(1, 8'h20 + OFF_CNT, 0);
      bus(1, 8'h20 + OFF_GRA, 0);
      bus(1, 8'h20 + OFF_CTRL, 32'h4);
      bus(1, OFF_RUN, 2);
      bus(1, 8'h20 + OFF_CNT, 32'h1234);
      bus(0, 8'h20 + OFF_CNT, 0);
      chk("clr wins", {16'h0, CNT_RST}, rd);
      $display("test capture done");
      // ch4 wrap from near all ones
      bus(1, 8'h80 + OFF_CTRL, 32'h1000);
      bus(1, OFF_RUN, 16);
      bus(1, 8'h80 + OFF_CNT, 32'hFFF0);
      while (iw[4] !== 1'b1) @(posedge core_clk);
      bus(0, 8'h80 + OFF_STAT, 0);
      chk("wrap flag", 1, 32'(rd[FLG_W]));
      chk("pin b4", 1, 32'(pb[4]));
      // reset-synchronized mode, then ch3 polarity inverted
      bus(1, OFF_FUNC, 32'(MODE_RSYNC));
      chk("pin a3", 1, 32'(pa[3]));
      bus(1, OFF_OUTC, 1);
      repeat (2) @(posedge core_clk);
      chk("pin a3 inv", 0, 32'(pa[3]));
      $display("test wrap done");
      end_sim();
   end
endmodule
`default_nettype wire
